// ==== hdl/acm_pkg.sv ====
// Constants and types shared by the configuration priority front end
package acm_pkg;

  // ************************************************************
  // Serial word layout
  // ************************************************************
  localparam int WORD_BITS = 16;
  localparam int ADDR_BITS = 5;
  localparam int DATA_BITS = 11;

  // ************************************************************
  // Register addresses (5-bit address field of a serial word)
  // ************************************************************
  localparam logic [4:0] REG_GLOBAL_CONTROL = 5'h00;
  localparam logic [4:0] REG_TEST_PATTERN_CONTROL = 5'h0A;
  localparam logic [4:0] REG_OVERRIDE_AND_GAIN_CONTROL = 5'h0D;

  // Reset values
  localparam logic [10:0] GLOBAL_CONTROL_RST = 11'h000;
  localparam logic [10:0] TEST_PATTERN_CONTROL_RST = 11'h000;
  localparam logic [10:0] OVERRIDE_AND_GAIN_CONTROL_RST = 11'h000;

  // ************************************************************
  // Field positions
  // ************************************************************
  // global_control
  localparam int GC_PWRDN_BIT = 0;
  localparam int GC_SOFT_RESET_BIT = 1;
  localparam int GC_CHAN_A_PD_BIT = 2;
  localparam int GC_CHAN_B_PD_BIT = 3;
  localparam int GC_REF_INTERNAL_BIT = 6;
  // test_pattern_control
  localparam int TP_PATTERN_LSB = 5;
  localparam int TP_PATTERN_MSB = 7;
  // override_and_gain_control
  localparam int OG_LANE_LSB = 0;
  localparam int OG_FACTOR_LSB = 2;
  localparam int OG_GAIN_BIT = 5;
  localparam int OG_ORDER_LSB = 7;
  localparam int OG_OVERRIDE_BIT = 10;

  // ************************************************************
  // Strap level codes and output pattern codes
  // ************************************************************
  localparam logic [1:0] LVL_GROUND = 2'h0;
  localparam logic [1:0] LVL_THREE_SIXTHS = 2'h1;
  localparam logic [1:0] LVL_FIVE_SIXTHS = 2'h2;
  localparam logic [1:0] LVL_SUPPLY = 2'h3;

  localparam logic [2:0] PAT_NORMAL = 3'h0;
  localparam logic [2:0] PAT_SYNC = 3'h1;
  localparam logic [2:0] PAT_DESKEW = 3'h2;

  // ************************************************************
  // Positions inside the synchronised pin vector
  // ************************************************************
  localparam int PIN_BITS = 17;
  localparam int P_RESET = 0;
  localparam int P_SEL_N = 1;
  localparam int P_SCLK = 2;
  localparam int P_SERIAL_SHIFT_DATA = 3;
  localparam int P_GPD = 4;
  localparam int P_APD = 5;
  localparam int P_BPD = 6;
  localparam int P_SEL_LVL = 7;
  localparam int P_LANE = 9;
  localparam int P_FACTOR = 11;
  localparam int P_RSVD = 13;
  localparam int P_ORDER = 15;

  typedef enum logic [1:0] {ACM_MODE_PIN, ACM_MODE_SERIAL, ACM_MODE_COMBINED} acm_mode_t;

endpackage

// ==== hdl/acm_config_top.sv ====
// Configuration source selection: strap pins versus serial control registers
`timescale 1ns/10ps
`default_nettype none

// Contract
// - After power-up the device configures itself from strap levels, no reset needed.
// - Pin-only mode: select, clock and data pins act as static straps.
// - Serial-only: host sets override bit D10 of 0x0D; then straps are ignored.
// - Combined mode: pins and registers both configure, fixed priority per function.
// - Strap functions follow register bits only while override bit is high.
// - Global power-down pin high forces power-down; else bit D0 of 0x00 rules outside pin-only mode.
// - Combined mode: coarse gain follows 0x0D D5 only with override, else 0 dB.
// - Combined mode: reference choice comes from bit D6 of 0x00.
// - Combined mode: bits D7..D5 of 0x0A select sync and deskew patterns.
// - Combined mode: software global power-down comes from bit D0 of 0x00.
// - Pin-only: clock/data both low normal; clock low data high gives sync.
// - Pin-only: clock high data low powers down everything.
// - Pin-only: clock and data both high gives deskew pattern.
// - First strap selects one or two lanes and DDR or SDR bit clock.
// - Second strap selects 12x or 14x serialization and SDR capture edge.
// - Fourth strap selects bit order and sample data format.
// - Each channel power-down strap powers down its own channel.
// - Pin-only: select pin level chooses coarse gain and reference.
// - First strap levels: DDR 1-lane, unused, SDR 2-lane, DDR 2-lane.
// - Second strap levels: 12x fall, 14x fall, 14x rise, 12x rise.
// - Fourth strap levels: MSB 2s, MSB offset, LSB offset, LSB 2s.
// - Serial word is 16 bits: 5-bit address then 11 data bits.
module acm_config_top
  import acm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Hardware register reset pin and three-wire port
  input wire logic reg_reset_pin,
  input wire logic serial_select_n,
  input wire logic serial_shift_clk,
  input wire logic serial_shift_data,
  // Strap pins, multi-level ones as decoded two-bit level codes
  input wire logic [1:0] serial_select_level,
  input wire logic [1:0] strap_lane_clocking,
  input wire logic [1:0] strap_serial_factor,
  input wire logic [1:0] strap_reserved,
  input wire logic [1:0] strap_order_format,
  input wire logic global_powerdown_pin,
  input wire logic chan_a_powerdown_pin,
  input wire logic chan_b_powerdown_pin,
  // Resolved configuration
  output acm_mode_t cfg_mode,
  output logic two_lane,
  output logic bitclk_sdr,
  output logic serial_14x,
  output logic capture_rising,
  output logic lsb_first,
  output logic offset_binary,
  output logic coarse_gain_high,
  output logic ref_internal,
  output logic global_powerdown,
  output logic chan_a_powerdown,
  output logic chan_b_powerdown,
  output logic [2:0] test_pattern,
  output logic strap_reserved_fault
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [PIN_BITS-1:0] pins_raw;
  logic [PIN_BITS-1:0] sync1_r;
  logic [PIN_BITS-1:0] sync2_r;

  assign pins_raw = {strap_order_format, strap_reserved, strap_serial_factor,
                     strap_lane_clocking, serial_select_level, chan_b_powerdown_pin,
                     chan_a_powerdown_pin, global_powerdown_pin, serial_shift_data,
                     serial_shift_clk, serial_select_n, reg_reset_pin};

  // Every pin is asynchronous to mclk; the first stage feeds only the second
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= pins_raw;
      sync2_r <= sync1_r;
    end
  end

  logic reset_pin_s;
  logic sel_n_s;
  logic sclk_s;
  logic serial_shift_data_s;

  assign reset_pin_s = sync2_r[P_RESET];
  assign sel_n_s = sync2_r[P_SEL_N];
  assign sclk_s = sync2_r[P_SCLK];
  assign serial_shift_data_s = sync2_r[P_SERIAL_SHIFT_DATA];

  // ************************************************************
  // Programming mode
  // ************************************************************
  logic [10:0] global_control_r;
  logic [10:0] test_pattern_control_r;
  logic [10:0] override_and_gain_control_r;
  logic override;
  logic pin_only;

  // A reset pin held high means the three-wire pins are straps
  assign pin_only = reset_pin_s;
  assign override = override_and_gain_control_r[OG_OVERRIDE_BIT];

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cfg_mode <= ACM_MODE_PIN;
    else if (pin_only)
      cfg_mode <= ACM_MODE_PIN;
    else if (override)
      cfg_mode <= ACM_MODE_SERIAL;
    else
      cfg_mode <= ACM_MODE_COMBINED;
  end

  // ************************************************************
  // Three-wire serial receiver
  // ************************************************************
  logic sclk_d_r;
  logic [WORD_BITS-2:0] shift_r;
  logic [3:0] bit_cnt_r;
  logic sclk_fall;
  logic word_done;
  logic [WORD_BITS-1:0] word;

  // Port is live only outside pin-only mode and while select is low
  assign sclk_fall = sclk_d_r && !sclk_s && !sel_n_s && !pin_only;
  assign word_done = sclk_fall && (bit_cnt_r == 4'hF);
  assign word = {shift_r, serial_shift_data_s};

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      sclk_d_r <= 1'b0;
    else
      sclk_d_r <= sclk_s;
  end

  // A partial word is dropped as the count restarts while select is high; bits beyond 16 start a new word
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      shift_r <= '0;
      bit_cnt_r <= 4'h0;
    end
    else if (sel_n_s || pin_only)
      bit_cnt_r <= 4'h0;
    else if (sclk_fall)
    begin
      shift_r <= word[WORD_BITS-2:0];
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end
  end

  // ************************************************************
  // Control registers
  // ************************************************************
  logic [ADDR_BITS-1:0] wr_addr;
  logic [DATA_BITS-1:0] wr_data;
  logic soft_reset;

  assign wr_addr = word[WORD_BITS-1:DATA_BITS];
  assign wr_data = word[DATA_BITS-1:0];
  // The soft reset bit is never stored, so it reads back as cleared
  assign soft_reset = word_done && (wr_addr == REG_GLOBAL_CONTROL)
                      && wr_data[GC_SOFT_RESET_BIT];

  // Reset pin high clears to defaults; in pin-only mode it stays high, holding them
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      global_control_r <= GLOBAL_CONTROL_RST;
      test_pattern_control_r <= TEST_PATTERN_CONTROL_RST;
      override_and_gain_control_r <= OVERRIDE_AND_GAIN_CONTROL_RST;
    end
    else if (reset_pin_s || soft_reset)
    begin
      global_control_r <= GLOBAL_CONTROL_RST;
      test_pattern_control_r <= TEST_PATTERN_CONTROL_RST;
      override_and_gain_control_r <= OVERRIDE_AND_GAIN_CONTROL_RST;
    end
    else if (word_done)
    begin
      unique case (wr_addr)
        REG_GLOBAL_CONTROL:
          global_control_r <= wr_data;
        REG_TEST_PATTERN_CONTROL:
          test_pattern_control_r <= wr_data;
        REG_OVERRIDE_AND_GAIN_CONTROL:
          override_and_gain_control_r <= wr_data;
        default:
          ;
      endcase
    end
  end

  // ************************************************************
  // Strap capture
  // ************************************************************
  logic [1:0] lane_strap_r;
  logic [1:0] factor_strap_r;
  logic [1:0] order_strap_r;
  logic [1:0] sel_lvl_strap_r;
  logic chan_a_strap_r;
  logic chan_b_strap_r;
  logic strap_live;

  // Straps are followed from reset release on, with no register reset needed
  assign strap_live = pin_only || !override;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lane_strap_r <= LVL_GROUND;
      factor_strap_r <= LVL_GROUND;
      order_strap_r <= LVL_GROUND;
      sel_lvl_strap_r <= LVL_GROUND;
      chan_a_strap_r <= 1'b0;
      chan_b_strap_r <= 1'b0;
    end
    else if (strap_live)
    begin
      lane_strap_r <= sync2_r[P_LANE+1:P_LANE];
      factor_strap_r <= sync2_r[P_FACTOR+1:P_FACTOR];
      order_strap_r <= sync2_r[P_ORDER+1:P_ORDER];
      sel_lvl_strap_r <= sync2_r[P_SEL_LVL+1:P_SEL_LVL];
      chan_a_strap_r <= sync2_r[P_APD];
      chan_b_strap_r <= sync2_r[P_BPD];
    end
  end

  // ************************************************************
  // Priority between straps and registers
  // ************************************************************
  logic [1:0] lane_code;
  logic [1:0] factor_code;
  logic [1:0] order_code;

  always_comb
  begin
    if (strap_live)
    begin
      lane_code = lane_strap_r;
      factor_code = factor_strap_r;
      order_code = order_strap_r;
    end
    else
    begin
      lane_code = override_and_gain_control_r[OG_LANE_LSB+1:OG_LANE_LSB];
      factor_code = override_and_gain_control_r[OG_FACTOR_LSB+1:OG_FACTOR_LSB];
      order_code = override_and_gain_control_r[OG_ORDER_LSB+1:OG_ORDER_LSB];
    end
  end

  // ************************************************************
  // Level decode
  // ************************************************************
  logic two_lane_nxt;
  logic bitclk_sdr_nxt;
  logic serial_14x_nxt;
  logic capture_rising_nxt;
  logic lsb_first_nxt;
  logic offset_binary_nxt;

  // The unused first-strap level falls back to the ground setting
  always_comb
  begin
    unique case (lane_code)
      LVL_FIVE_SIXTHS:
      begin
        two_lane_nxt = 1'b1;
        bitclk_sdr_nxt = 1'b1;
      end
      LVL_SUPPLY:
      begin
        two_lane_nxt = 1'b1;
        bitclk_sdr_nxt = 1'b0;
      end
      default:
      begin
        two_lane_nxt = 1'b0;
        bitclk_sdr_nxt = 1'b0;
      end
    endcase
  end

  // Only meaningful in two-lane SDR; downstream serializer ignores it otherwise
  always_comb
  begin
    unique case (factor_code)
      LVL_GROUND:
      begin
        serial_14x_nxt = 1'b0;
        capture_rising_nxt = 1'b0;
      end
      LVL_THREE_SIXTHS:
      begin
        serial_14x_nxt = 1'b1;
        capture_rising_nxt = 1'b0;
      end
      LVL_FIVE_SIXTHS:
      begin
        serial_14x_nxt = 1'b1;
        capture_rising_nxt = 1'b1;
      end
      LVL_SUPPLY:
      begin
        serial_14x_nxt = 1'b0;
        capture_rising_nxt = 1'b1;
      end
    endcase
  end

  always_comb
  begin
    unique case (order_code)
      LVL_GROUND:
      begin
        lsb_first_nxt = 1'b0;
        offset_binary_nxt = 1'b0;
      end
      LVL_THREE_SIXTHS:
      begin
        lsb_first_nxt = 1'b0;
        offset_binary_nxt = 1'b1;
      end
      LVL_FIVE_SIXTHS:
      begin
        lsb_first_nxt = 1'b1;
        offset_binary_nxt = 1'b1;
      end
      LVL_SUPPLY:
      begin
        lsb_first_nxt = 1'b1;
        offset_binary_nxt = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // Gain, reference, power-down and test pattern
  // ************************************************************
  logic coarse_gain_high_nxt;
  logic ref_internal_nxt;
  logic global_powerdown_nxt;
  logic chan_a_powerdown_nxt;
  logic chan_b_powerdown_nxt;
  logic [2:0] test_pattern_nxt;

  always_comb
  begin
    if (pin_only)
    begin
      coarse_gain_high_nxt = (sel_lvl_strap_r == LVL_THREE_SIXTHS)
                             || (sel_lvl_strap_r == LVL_FIVE_SIXTHS);
      ref_internal_nxt = sel_lvl_strap_r[1];
      unique case ({sclk_s, serial_shift_data_s})
        2'b01:
        begin
          test_pattern_nxt = PAT_SYNC;
          global_powerdown_nxt = 1'b0;
        end
        2'b10:
        begin
          test_pattern_nxt = PAT_NORMAL;
          global_powerdown_nxt = 1'b1;
        end
        2'b11:
        begin
          test_pattern_nxt = PAT_DESKEW;
          global_powerdown_nxt = 1'b0;
        end
        default:
        begin
          test_pattern_nxt = PAT_NORMAL;
          global_powerdown_nxt = 1'b0;
        end
      endcase
    end
    else
    begin
      coarse_gain_high_nxt = override && override_and_gain_control_r[OG_GAIN_BIT];
      ref_internal_nxt = global_control_r[GC_REF_INTERNAL_BIT];
      test_pattern_nxt = test_pattern_control_r[TP_PATTERN_MSB:TP_PATTERN_LSB];
      global_powerdown_nxt = global_control_r[GC_PWRDN_BIT];
    end
    // The pin wins over software in every mode
    if (sync2_r[P_GPD])
      global_powerdown_nxt = 1'b1;
    // With straps ignored, channel power-down moves to register bits
    if (strap_live)
    begin
      chan_a_powerdown_nxt = chan_a_strap_r;
      chan_b_powerdown_nxt = chan_b_strap_r;
    end
    else
    begin
      chan_a_powerdown_nxt = global_control_r[GC_CHAN_A_PD_BIT];
      chan_b_powerdown_nxt = global_control_r[GC_CHAN_B_PD_BIT];
    end
  end

  // ************************************************************
  // Output registers
  // ************************************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      two_lane <= 1'b0;
      bitclk_sdr <= 1'b0;
      serial_14x <= 1'b0;
      capture_rising <= 1'b0;
      lsb_first <= 1'b0;
      offset_binary <= 1'b0;
    end
    else
    begin
      two_lane <= two_lane_nxt;
      bitclk_sdr <= bitclk_sdr_nxt;
      serial_14x <= serial_14x_nxt;
      capture_rising <= capture_rising_nxt;
      lsb_first <= lsb_first_nxt;
      offset_binary <= offset_binary_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      coarse_gain_high <= 1'b0;
      ref_internal <= 1'b0;
      global_powerdown <= 1'b0;
      chan_a_powerdown <= 1'b0;
      chan_b_powerdown <= 1'b0;
      test_pattern <= PAT_NORMAL;
      strap_reserved_fault <= 1'b0;
    end
    else
    begin
      coarse_gain_high <= coarse_gain_high_nxt;
      ref_internal <= ref_internal_nxt;
      global_powerdown <= global_powerdown_nxt;
      chan_a_powerdown <= chan_a_powerdown_nxt;
      chan_b_powerdown <= chan_b_powerdown_nxt;
      test_pattern <= test_pattern_nxt;
      // Flags a board that left the reserved strap off ground
      strap_reserved_fault <= (sync2_r[P_RSVD+1:P_RSVD] != LVL_GROUND);
    end
  end

endmodule

`default_nettype wire

// ==== dv/acm_config_top_sva.sv ====
// Assertion checker for the configuration priority front end
`timescale 1ns/10ps
`default_nettype none
module acm_config_top_sva
  import acm_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins
  input wire logic reg_reset_pin,
  input wire logic serial_shift_clk,
  input wire logic serial_shift_data,
  input wire logic [1:0] serial_select_level,
  input wire logic [1:0] strap_lane_clocking,
  input wire logic [1:0] strap_serial_factor,
  input wire logic [1:0] strap_order_format,
  input wire logic global_powerdown_pin,
  input wire logic chan_a_powerdown_pin,
  input wire logic chan_b_powerdown_pin,
  // Resolved configuration
  input wire acm_mode_t cfg_mode,
  input wire logic two_lane,
  input wire logic bitclk_sdr,
  input wire logic serial_14x,
  input wire logic capture_rising,
  input wire logic lsb_first,
  input wire logic offset_binary,
  input wire logic coarse_gain_high,
  input wire logic ref_internal,
  input wire logic global_powerdown,
  input wire logic chan_a_powerdown,
  input wire logic chan_b_powerdown,
  input wire logic [2:0] test_pattern
);
  // ************************************************************
  // Pin history
  // ************************************************************
  // Pins reach the outputs three or four edges late, so a pin set is
  // judged only once it held over both depths
  logic [13:0] pv;
  logic [13:0] d1_r, d2_r, d3_r, d4_r;
  logic [2:0] up_r;
  logic calm;
  assign pv = {reg_reset_pin, serial_shift_clk, serial_shift_data, serial_select_level,
    strap_lane_clocking, strap_serial_factor, strap_order_format, global_powerdown_pin,
    chan_a_powerdown_pin, chan_b_powerdown_pin};
  assign calm = (up_r == 3'h7) && (d3_r == d4_r) && d3_r[13];
  always_ff @(posedge mclk)
  begin
    d1_r <= pv;
    d2_r <= d1_r;
    d3_r <= d2_r;
    d4_r <= d3_r;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      up_r <= 3'h0;
    else if (up_r != 3'h7)
      up_r <= up_r + 3'h1;
  end

  // ************************************************************
  // Properties
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  pin_mode_a: assert property (calm |-> cfg_mode == ACM_MODE_PIN)
    else $error("mode is not pin-only with reset pin high");
  pin_pattern_a: assert property (calm |-> test_pattern ==
    (d3_r[12:11] == 2'h1 ? PAT_SYNC : (d3_r[12:11] == 2'h3 ? PAT_DESKEW : PAT_NORMAL)))
    else $error("pin-only test pattern wrong");
  pin_pwrdn_a: assert property (calm |->
    global_powerdown == (d3_r[2] | (d3_r[12:11] == 2'h2)))
    else $error("pin-only global power-down wrong");
  pdn_force_a: assert property (global_powerdown_pin |-> ##3 global_powerdown)
    else $error("power-down pin did not force power-down");
  lane_decode_a: assert property (calm |->
    two_lane == d3_r[8] && bitclk_sdr == (d3_r[8:7] == 2'h2))
    else $error("lane and bit clock decode wrong");
  factor_decode_a: assert property (calm |->
    serial_14x == ^d3_r[6:5] && capture_rising == d3_r[6])
    else $error("serialization decode wrong");
  order_decode_a: assert property (calm |->
    lsb_first == d3_r[4] && offset_binary == ^d3_r[4:3])
    else $error("order and format decode wrong");
  chan_pd_a: assert property (calm |->
    chan_a_powerdown == d3_r[1] && chan_b_powerdown == d3_r[0])
    else $error("channel power-down wrong");
  gain_ref_a: assert property (calm |->
    coarse_gain_high == ^d3_r[10:9] && ref_internal == d3_r[10])
    else $error("gain and reference decode wrong");
  combined_gain_a: assert property (cfg_mode == ACM_MODE_COMBINED |-> !coarse_gain_high)
    else $error("coarse gain raised without override");
endmodule

bind acm_config_top acm_config_top_sva chk (
  .mclk, .rst, .reg_reset_pin, .serial_shift_clk, .serial_shift_data, .serial_select_level,
  .strap_lane_clocking, .strap_serial_factor, .strap_order_format, .global_powerdown_pin,
  .chan_a_powerdown_pin, .chan_b_powerdown_pin, .cfg_mode, .two_lane, .bitclk_sdr,
  .serial_14x, .capture_rising, .lsb_first, .offset_binary, .coarse_gain_high, .ref_internal,
  .global_powerdown, .chan_a_powerdown, .chan_b_powerdown, .test_pattern
);
`default_nettype wire

// ==== dv/acm_host_model.sv ====
// Host controller model: static strap levels and three-wire register writes
`timescale 1ns/10ps
`default_nettype none
module acm_host_model (
  // Three-wire port, static straps in pin-only mode
  output var logic serial_select_n,
  output var logic serial_shift_clk,
  output var logic serial_shift_data
);
  initial
  begin
    serial_select_n = 1'b1;
    serial_shift_clk = 1'b0;
    serial_shift_data = 1'b0;
  end

  task automatic set_straps(input logic clk_lvl, input logic data_lvl);
    serial_shift_clk = clk_lvl;
    serial_shift_data = data_lvl;
  endtask

  // Sends the top n bits of w, address first; fewer than 16 must be dropped
  task automatic send(input logic [15:0] w, input int n);
    int i;
    serial_select_n = 1'b0;
    #40;
    for (i = 15; i > 15 - n; i--)
    begin
      serial_shift_data = w[i];
      serial_shift_clk = 1'b1;
      #62.5;
      serial_shift_clk = 1'b0;
      #62.5;
    end
    // Data line has no pull, so it is not left at the last bit
    serial_shift_data = ~serial_shift_data;
    #40;
    serial_select_n = 1'b1;
    #40;
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_adc_config_mode_priority.sv ====
// Self-checking bench for the configuration priority front end
`timescale 1ns/10ps
`default_nettype none
module tb_adc_config_mode_priority
  import acm_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic reg_reset_pin = 1'b1;
  logic [1:0] serial_select_level = 2'h0;
  logic [1:0] strap_lane_clocking = 2'h0;
  logic [1:0] strap_serial_factor = 2'h0;
  logic [1:0] strap_order_format = 2'h0;
  logic global_powerdown_pin = 1'b0;
  logic chan_a_powerdown_pin = 1'b0;
  logic chan_b_powerdown_pin = 1'b0;
  wire logic serial_select_n, serial_shift_clk, serial_shift_data;
  acm_mode_t cfg_mode;
  logic two_lane, bitclk_sdr, serial_14x, capture_rising, lsb_first, offset_binary;
  logic coarse_gain_high, ref_internal, global_powerdown, chan_a_powerdown, chan_b_powerdown;
  logic [2:0] test_pattern;
  logic [15:0] cfg_out;
  logic [1:0] scd;
  logic [2:0] pat;
  integer seed = 32'h98f7_1249;
  int err_count = 0;
  int n_compared = 0;

  assign cfg_out = {cfg_mode, two_lane, bitclk_sdr, serial_14x, capture_rising, lsb_first,
    offset_binary, coarse_gain_high, ref_internal, global_powerdown, chan_a_powerdown,
    chan_b_powerdown, test_pattern};

  always #5 mclk = ~mclk;

  acm_config_top uut (
    .mclk, .rst, .reg_reset_pin, .serial_select_n, .serial_shift_clk, .serial_shift_data,
    .serial_select_level, .strap_lane_clocking, .strap_serial_factor,
    .strap_reserved(2'h0),
    .strap_order_format, .global_powerdown_pin, .chan_a_powerdown_pin, .chan_b_powerdown_pin,
    .cfg_mode, .two_lane, .bitclk_sdr, .serial_14x, .capture_rising, .lsb_first, .offset_binary,
    .coarse_gain_high, .ref_internal, .global_powerdown, .chan_a_powerdown, .chan_b_powerdown,
    .test_pattern, .strap_reserved_fault()
  );
  acm_host_model host (.serial_select_n, .serial_shift_clk, .serial_shift_data);

  // ************************************************************
  // Expectations, comparison and verdict
  // ************************************************************
  function automatic logic [15:0] exp_of(input acm_mode_t m, input logic [1:0] ln,
    input logic [1:0] fc, input logic [1:0] oc, input logic g, input logic r, input logic gp,
    input logic a, input logic b, input logic [2:0] p);
    return {m, ln[1], ln == LVL_FIVE_SIXTHS, ^fc, fc[1], oc[1], ^oc, g, r, gp, a, b, p};
  endfunction

  // Straps still rule the interface in combined mode; gain stays at 0 dB
  function automatic logic [15:0] cmb_exp(input logic r, input logic gp, input logic [2:0] p);
    return exp_of(ACM_MODE_COMBINED, strap_lane_clocking, strap_serial_factor,
      strap_order_format, 1'b0, r, gp, chan_a_powerdown_pin, chan_b_powerdown_pin, p);
  endfunction

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [10:0] d);
    host.send({a, d}, 16);
    repeat (8) @(negedge mclk);
  endtask

  initial
  begin
    #200_000;
    err_count++;
    print_verdict();
  end

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    // Pin-only: all four clock/data combinations first, then random
    for (int i = 0; i < 48; i++)
    begin
      {serial_select_level, strap_lane_clocking, strap_serial_factor, strap_order_format,
        global_powerdown_pin, chan_a_powerdown_pin, chan_b_powerdown_pin} = 11'($random(seed));
      scd = (i < 4) ? 2'(i) : 2'($random(seed));
      host.set_straps(scd[1], scd[0]);
      pat = scd == 2'h1 ? PAT_SYNC : (scd == 2'h3 ? PAT_DESKEW : PAT_NORMAL);
      repeat (6) @(negedge mclk);
      check(cfg_out, exp_of(ACM_MODE_PIN,
        strap_lane_clocking, strap_serial_factor, strap_order_format, ^serial_select_level,
        serial_select_level[1], global_powerdown_pin | (scd == 2'h2), chan_a_powerdown_pin,
        chan_b_powerdown_pin, pat));
    end
    // Combined mode after the reset pin is released
    host.set_straps(1'b0, 1'b0);
    global_powerdown_pin = 1'b0;
    reg_reset_pin = 1'b0;
    repeat (8) @(negedge mclk);
    check(cfg_out, cmb_exp(1'b0, 1'b0, PAT_NORMAL));
    wr(REG_GLOBAL_CONTROL, 11'h041);
    check(cfg_out, cmb_exp(1'b1, 1'b1, PAT_NORMAL));
    wr(REG_OVERRIDE_AND_GAIN_CONTROL, 11'h020);
    check(cfg_out, cmb_exp(1'b1, 1'b1, PAT_NORMAL));
    for (int p = 0; p < 8; p++)
    begin
      wr(REG_TEST_PATTERN_CONTROL, 11'(p << 5));
      check(cfg_out, cmb_exp(1'b1, 1'b1, 3'(p)));
    end
    wr(REG_GLOBAL_CONTROL, 11'h040);
    global_powerdown_pin = 1'b1;
    repeat (6) @(negedge mclk);
    check(cfg_out, cmb_exp(1'b1, 1'b1, 3'h7));
    {global_powerdown_pin, chan_a_powerdown_pin, chan_b_powerdown_pin} = 3'h0;
    // Unmapped address and a short word leave everything alone
    wr(5'h05, 11'h7ff);
    host.send({REG_OVERRIDE_AND_GAIN_CONTROL, 11'h4ab}, 15);
    repeat (8) @(negedge mclk);
    check(cfg_out, cmb_exp(1'b1, 1'b0, 3'h7));
    // Serial-only: straps grounded, override set, then straps wiggled
    {strap_lane_clocking, strap_serial_factor, strap_order_format} = 6'h00;
    wr(REG_OVERRIDE_AND_GAIN_CONTROL, 11'h4ab);
    {strap_lane_clocking, strap_serial_factor, strap_order_format} = 6'($random(seed));
    repeat (8) @(negedge mclk);
    check(cfg_out, exp_of(ACM_MODE_SERIAL, 2'h3, 2'h2, 2'h1, 1'b1, 1'b1,
      1'b0, 1'b0, 1'b0, 3'h7));
    wr(REG_GLOBAL_CONTROL, 11'h04c);
    check(cfg_out, exp_of(ACM_MODE_SERIAL, 2'h3, 2'h2, 2'h1, 1'b1, 1'b1,
      1'b0, 1'b1, 1'b1, 3'h7));
    // Soft reset returns every register to default
    wr(REG_GLOBAL_CONTROL, 11'h002);
    check(cfg_out, cmb_exp(1'b0, 1'b0, PAT_NORMAL));
    check(16'(uut.strap_reserved_fault), 16'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
